// ==== pkg/ch1_cfg_pkg.sv ====
`default_nettype none
package ch1_cfg_pkg;
   localparam int          DATA_W         = 32;
   localparam int          FREQ_MSB       = 31;
   localparam int          FREQ_LSB       = 30;
   localparam int          DELAY_MSB      = 18;
   localparam int          DELAY_LSB      = 8;
   localparam int          DELAY_W        = 11;
   localparam logic [1:0]  FREQ_RESET     = 2'h0;
   localparam logic [10:0] DELAY_RESET    = 11'h000;
   localparam logic [1:0]  SEL_DIV1       = 2'h0;
   localparam logic [1:0]  SEL_DIV2       = 2'h1;
   localparam logic [1:0]  SEL_DIV4       = 2'h2;
   localparam logic [1:0]  SEL_DIV20      = 2'h3;
   localparam logic [4:0]  RATIO_DIV1     = 5'h01;
   localparam logic [4:0]  RATIO_DIV2     = 5'h02;
   localparam logic [4:0]  RATIO_DIV4     = 5'h04;
   localparam logic [4:0]  RATIO_DIV20    = 5'h14;
endpackage
`default_nettype wire

// ==== rtl/ch1_drive_timing_config.sv ====
`default_nettype none
// What this block does
// - Two-bit read/write base frequency select in bits 31:30, reset to zero.
// - Select 00 passes external clock undivided; 01 divides it by two.
// - Select 10 divides external clock by four; 11 divides it by twenty.
// - Eleven-bit read/write ON delay counter in bits 18:8, reset to zero.
// - ON delay applies only while the first channel runs under serial control.
module ch1_drive_timing_config
   import ch1_cfg_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               reg_wr,
   input  wire logic [DATA_W-1:0]  reg_wdata,
   output logic      [DATA_W-1:0]  reg_rdata,
   input  wire logic               ext_clk_in,
   input  wire logic               serial_ctrl,
   output logic                    base_freq_tick,
   output logic      [DELAY_W-1:0] on_delay
);

   ////////////////////////////////////////////////////////////////////////
   // The two stored fields and the values they take at the next edge.
   logic [1:0]         freq_sel;
   logic [DELAY_W-1:0] delay_val;
   logic [1:0]         next_freq_sel;
   logic [DELAY_W-1:0] next_delay_val;
   logic [DATA_W-1:0]  next_rdata;

   // Synchroniser, edge detector and divider state.
   logic               ext_meta;
   logic               ext_sync;
   logic               ext_prev;
   logic               ext_rise;
   logic [4:0]         div_cnt;
   logic [4:0]         next_div_cnt;
   logic               next_tick;
   logic [DELAY_W-1:0] next_on_delay;

   ////////////////////////////////////////////////////////////////////////
   // Divide ratio for a select code; any code not listed takes the slowest ratio.
   function automatic logic [4:0] ratio_of(input logic [1:0] sel);
      case (sel)
         SEL_DIV1:  ratio_of = RATIO_DIV1;
         SEL_DIV2:  ratio_of = RATIO_DIV2;
         SEL_DIV4:  ratio_of = RATIO_DIV4;
         default:   ratio_of = RATIO_DIV20;
      endcase
   endfunction

   // Base frequency field of a bus word.
   function automatic logic [1:0] freq_field(input logic [DATA_W-1:0] word);
      freq_field = word[FREQ_MSB:FREQ_LSB];
   endfunction

   // ON delay field of a bus word.
   function automatic logic [DELAY_W-1:0] delay_field(input logic [DATA_W-1:0] word);
      delay_field = word[DELAY_MSB:DELAY_LSB];
   endfunction

   // Builds the readback word; every bit outside the two fields is zero.
   function automatic logic [DATA_W-1:0] pack_word(input logic [1:0] sel, input logic [DELAY_W-1:0] dly);
      pack_word                      = '0;
      pack_word[FREQ_MSB:FREQ_LSB]   = sel;
      pack_word[DELAY_MSB:DELAY_LSB] = dly;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // A write replaces both fields at once; there is no partial write.
   always_comb
   begin
      next_freq_sel  = freq_sel;
      next_delay_val = delay_val;
      if (reg_wr)
      begin
         next_freq_sel  = freq_field(reg_wdata);
         next_delay_val = delay_field(reg_wdata);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         freq_sel <= FREQ_RESET;
      end
      else
      begin
         freq_sel <= next_freq_sel;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         delay_val <= DELAY_RESET;
      end
      else
      begin
         delay_val <= next_delay_val;
      end
   end

   // Only the two fields are stored, so reserved bits cannot hold stray writes.
   always_comb
   begin
      next_rdata = pack_word(freq_sel, delay_val);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         reg_rdata <= '0;
      end
      else
      begin
         reg_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // The external clock is sampled, so it must run well below clk/4.
   // Two flops settle metastability; the third only keeps the last level.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ext_meta <= 1'b0;
      end
      else
      begin
         ext_meta <= ext_clk_in;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ext_sync <= 1'b0;
      end
      else
      begin
         ext_sync <= ext_meta;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ext_prev <= 1'b0;
      end
      else
      begin
         ext_prev <= ext_sync;
      end
   end

   // All three flops reset low, matching the idle pin, so no false rise follows reset.
   always_comb
   begin
      ext_rise = ext_sync && !ext_prev;
   end

   ////////////////////////////////////////////////////////////////////////
   // The count compares with >= so a smaller ratio written mid-count wraps on the next external rise.
   always_comb
   begin
      next_div_cnt = div_cnt;
      next_tick    = 1'b0;
      if (ext_rise)
      begin
         if (div_cnt + 5'h01 >= ratio_of(freq_sel))
         begin
            next_div_cnt = 5'h00;
            next_tick    = 1'b1;
         end
         else
         begin
            next_div_cnt = div_cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         div_cnt <= 5'h00;
      end
      else
      begin
         div_cnt <= next_div_cnt;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         base_freq_tick <= 1'b0;
      end
      else
      begin
         base_freq_tick <= next_tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin-driven operation gets no programmed delay.
   always_comb
   begin
      if (serial_ctrl)
      begin
         next_on_delay = delay_val;
      end
      else
      begin
         next_on_delay = DELAY_RESET;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         on_delay <= DELAY_RESET;
      end
      else
      begin
         on_delay <= next_on_delay;
      end
   end

endmodule
`default_nettype wire

// ==== verif/ch1_cfg_assertions.sv ====
`default_nettype none
module ch1_cfg_assertions import ch1_cfg_pkg::*;
(input wire logic clk, rst_n, reg_wr, base_freq_tick, serial_ctrl,
 input wire logic [31:0] reg_wdata, reg_rdata, input wire logic [10:0] on_delay);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   field_store_a: assert property
      (reg_wr ##1 !reg_wr |=> reg_rdata == ($past(reg_wdata, 2) & 32'hc007ff00)) else $error("bad readback");
   reserved_zero_a: assert property
      (reg_rdata[29:19] == 11'h0 && reg_rdata[7:0] == 8'h0) else $error("reserved set");
   delay_gate_a: assert property
      (!serial_ctrl ##1 !serial_ctrl |-> on_delay == 11'h0) else $error("delay leak");
   tick_pulse_a: assert property
      (base_freq_tick |=> !base_freq_tick) else $error("long tick");
   delay_follow_a: assert property
      (serial_ctrl |=> on_delay == reg_rdata[18:8]) else $error("delay not applied");
   reset_clear_a: assert property
      (disable iff (1'b0) !rst_n |=> reg_rdata == 32'h0 && on_delay == 11'h0 && !base_freq_tick)
      else $error("reset not clear");
endmodule
`default_nettype wire

// ==== verif/ext_clk_src.sv ====
`default_nettype none
module ext_clk_src (input wire logic run, output logic ext_clk_in);
   timeunit 1ns; timeprecision 1ns;
   initial ext_clk_in = 1'h0;
   // Whole bursts of twenty rising edges keep every ratio's tick count exact.
   always @(posedge run)
      repeat (20)
      begin
         #200 ext_clk_in = 1'h1;
         #200 ext_clk_in = 1'h0;
      end
endmodule
`default_nettype wire

// ==== verif/ch1_drive_timing_config_bench.sv ====
`default_nettype none
module ch1_drive_timing_config_bench import ch1_cfg_pkg::*; ;
   timeunit 1ns; timeprecision 1ns;
   logic clk = 0, rst_n = 0, reg_wr = 0, serial_ctrl = 0, run = 0, ext_clk_in, base_freq_tick;
   logic [31:0] reg_wdata = 0, reg_rdata;
   logic [10:0] on_delay;
   int miscompares = 0, comparisons = 0, cycles = 0, ticks = 0;
   always #25 clk = ~clk;
   ch1_drive_timing_config u_ch1_drive_timing_config (.clk, .rst_n, .reg_wr, .reg_wdata,
      .reg_rdata, .ext_clk_in, .serial_ctrl, .base_freq_tick, .on_delay);
   ext_clk_src u_ext_clk_src (.run, .ext_clk_in);
   always @(posedge clk)
   begin
      ticks += (base_freq_tick === 1'h1);
      if (++cycles == 2000)
      begin
         miscompares++;
         end_sim();
      end
   end
   task chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("FAIL %0t %h %h", $time, g, e);
      end
   endtask
   task end_sim;
      $display("%0d compares %0d bad", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk) #1 chk(reg_rdata, 0);
      for (int s = 0; s < 4; s++)
      begin
         @(posedge clk);
         reg_wr <= 1'h1;
         reg_wdata <= {2'(s), 11'h7ff, 11'h7ff >> (3 - s), 8'hff};
         serial_ctrl <= s[0];
         @(posedge clk);
         reg_wr <= 1'h0;
         run <= 1'h1;
         ticks = 0;
         repeat (181) @(posedge clk);
         run <= 1'h0;
         #1 chk(reg_rdata, {2'(s), 11'h0, 11'h7ff >> (3 - s), 8'h0});
         chk(on_delay, s[0] ? 11'h7ff >> (3 - s) : 0);
         chk(ticks, s == 3 ? 1 : 20 >> s);
         $display("sel %0d done", s);
      end
      end_sim();
   end
endmodule
bind ch1_drive_timing_config ch1_cfg_assertions u_ch1_cfg_assertions (.clk, .rst_n, .reg_wr,
   .base_freq_tick, .serial_ctrl, .reg_wdata, .reg_rdata, .on_delay);
`default_nettype wire
